// ==== rsdc_regs.svh ====
// Constants for the reset source and debug connect block.
// Assumes inclusion by bare name from the same folder.
`ifndef RSDC_REGS_SVH
`define RSDC_REGS_SVH
// Internal fast oscillator rate and core clock divide ratio
`define RSDC_OSC_MHZ        16
`define RSDC_CORE_DIV       8
// Reset source bit positions in the cause vector
`define RSDC_SRC_POR        0
`define RSDC_SRC_WDG_IND    1
`define RSDC_SRC_WDG_WIN    2
`define RSDC_SRC_SOFT       3
`define RSDC_SRC_DEBUG      4
`define RSDC_SRC_OPCODE     5
`define RSDC_SRC_COUNT      6
// Reset values, program memory end and negate opcode
`define RSDC_CAUSE_RST      6'h01
`define RSDC_PC_RST         16'h8000
`define RSDC_PROG_END       16'h9FFF
`define RSDC_NEG_OPCODE     8'h00
// Debug link timing in system cycles
`define RSDC_LINK_ACTIVE_CY 8'h40
`define RSDC_LINK_IDLE_CY   8'h80
`endif

// ==== rsdc_pkg.sv ====
// Types for the reset source and debug connect block.
// Assumes the constants header is compiled alongside.
package rsdc_pkg;
  // Debug link connection states
  typedef enum logic [1:0] {
    RSDC_LINK_IDLE,
    RSDC_LINK_ENTRY,
    RSDC_LINK_CONNECTED
  } rsdc_link_t;
  // Pin function selection
  typedef enum logic {
    RSDC_PIN_DEBUG,
    RSDC_PIN_GPIO
  } rsdc_pin_t;
endpackage

// ==== rsdc_clkdiv.sv ====
// Core clock divider: one-cycle enable pulse every DIV system cycles.
// Assumes sys_clk is the internal fast oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "rsdc_regs.svh"
module rsdc_clkdiv #(
  parameter int DIV = `RSDC_CORE_DIV
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic sync_rst,
  output logic      core_en
);
  // Refuse divide ratios the 8-bit counter cannot serve
  if (DIV < 2 || DIV > 256) begin : g_div_range
    $error("rsdc_clkdiv: DIV out of range");
  end
  logic [7:0] cnt_r;   // Divider count
  logic [7:0] cnt_nxt; // Next count
  logic       rst_d_r; // Internal reset level one cycle ago
  logic       restart; // First cycle of a new internal reset
  // The divider keeps running in reset so a release tick always comes;
  // a new reset restarts the period so it lasts a full core period
  assign restart = sync_rst && !rst_d_r;
  // Next count, wraps at DIV-1
  always_comb begin
    if (restart || cnt_r == 8'(DIV - 1)) cnt_nxt = 8'h00;
    else cnt_nxt = cnt_r + 8'h01;
  end
  // Count register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r   <= 8'h00;
      rst_d_r <= 1'b1;
    end else begin
      cnt_r   <= cnt_nxt;
      rst_d_r <= sync_rst;
    end
  end
  // Pulse on the last count of each period; RQ15
  assign core_en = !restart && (cnt_r == 8'(DIV - 1));
endmodule
`default_nettype wire

// ==== rsdc_fetch.sv ====
// Program counter sequencing with illegal opcode detection.
// Assumes fetch data arrives with the counter each core enable.
`timescale 1ns/1ps
`default_nettype none
`include "rsdc_regs.svh"
module rsdc_fetch (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        sync_rst,
  input  wire logic        core_en,
  input  wire logic [7:0]  fetch_data,
  input  wire logic        opcode_valid,
  output logic [15:0]      pc,
  output logic             in_unimpl,
  output logic             opcode_bad
);
  logic [15:0] pc_r;   // Program counter
  logic [15:0] pc_nxt; // Next counter
  logic        bad_r;  // Registered illegal opcode flag
  logic        bad_nxt;
  // Zero byte is the negate instruction and always valid; RQ7
  function automatic logic is_legal(input logic [7:0] d, input logic v);
    is_legal = (d == `RSDC_NEG_OPCODE) || v;
  endfunction
  // Sequential advance; fetch keeps going past the end; RQ8
  always_comb begin
    pc_nxt  = pc_r;
    bad_nxt = 1'b0;
    if (sync_rst) begin
      pc_nxt = `RSDC_PC_RST;
    end else if (core_en) begin
      pc_nxt  = pc_r + 16'h0001; // RQ7
      bad_nxt = !is_legal(fetch_data, opcode_valid); // RQ6
    end
  end
  // Registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r  <= `RSDC_PC_RST;
      bad_r <= 1'b0;
    end else begin
      pc_r  <= pc_nxt;
      bad_r <= bad_nxt;
    end
  end
  assign pc         = pc_r;
  assign opcode_bad = bad_r;
  assign in_unimpl  = pc_r > `RSDC_PROG_END; // RQ8
endmodule
`default_nettype wire

// ==== rsdc_top.sv ====
// Reset aggregation, core clock enable, fetch and debug link connect.
// Assumes supply monitor levels and link pin are synchronous to sys_clk.
//
// Function
// RQ1: No reset pin; first reset from power-on.
// RQ2: Hold reset until supply monitor becomes operative.
// RQ3: Either watchdog event asserts internal reset.
// RQ4: Software reset request uses common reset path.
// RQ5: Debug host request makes full reset.
// RQ6: Illegal opcode raises internal reset.
// RQ7: Zero bytes decode as negate, pc advances.
// RQ8: Fetch continues past end of program memory.
// RQ9: Internal reset aborts running debug connection.
// RQ10: Host connects only while device runs code.
// RQ11: Pin debug after reset; GPIO blocks connects.
// RQ12: One open-drain line for programming and debug.
// RQ13: Memory access without halting the program.
// RQ14: Unbonded GPIOs float as inputs on reset.
// RQ15: Core clock is oscillator divided by eight.
// RQ16: Supply monitor resets below threshold with hysteresis.
// RQ17: Combined reset, synchronous release, link to idle.
`timescale 1ns/1ps
`default_nettype none
`include "rsdc_regs.svh"
module rsdc_top
  import rsdc_pkg::*;
#(
  parameter int NGPIO = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             supply_above_rise,
  input  wire logic             supply_above_fall,
  input  wire logic             wdg_ind_event,
  input  wire logic             wdg_win_event,
  input  wire logic             soft_reset_req,
  input  wire logic [7:0]       fetch_data,
  input  wire logic             opcode_valid,
  input  wire rsdc_pkg::rsdc_pin_t pin_func,
  input  wire logic             link_in,
  input  wire logic             link_host_reset,
  input  wire logic             mem_req,
  input  wire logic             mem_we,
  input  wire logic [15:0]      mem_addr,
  input  wire logic [7:0]       mem_wdata,
  input  wire logic [NGPIO-1:0] gpio_unbonded,
  output logic                  int_reset,
  output logic [5:0]            reset_cause,
  output logic                  core_en,
  output logic [15:0]           pc,
  output logic                  in_unimpl,
  output logic                  link_out,
  output logic                  link_oe,
  output logic                  link_connected,
  output logic                  bus_req,
  output logic                  bus_we,
  output logic [15:0]           bus_addr,
  output logic [7:0]            bus_wdata,
  output logic                  cpu_halt,
  output logic [NGPIO-1:0]      gpio_force_float
);
  import rsdc_pkg::*;

  if (NGPIO < 1 || NGPIO > 64) begin : g_ngpio_range
    $error("rsdc_top: NGPIO out of range");
  end

  logic        supply_ok_r;   // Hysteretic supply monitor state
  logic        supply_ok_nxt;
  logic        opcode_bad;    // Illegal opcode from fetch
  logic [5:0]  src_now;       // Reset sources this cycle
  logic        rst_hold_r;    // Combined reset, registered
  logic        rst_hold_nxt;
  logic        rst_sync_r;    // Release stage on core enable
  logic        rst_sync_nxt;
  logic [5:0]  cause_r;       // Sticky last reset cause
  logic [5:0]  cause_nxt;
  rsdc_link_t  link_st_r;     // Debug link state
  rsdc_link_t  link_st_nxt;
  logic [7:0]  lcnt_r;        // Link low-time counter
  logic [7:0]  lcnt_nxt;
  logic        dbg_req_r;     // Debug reset request pulse
  logic        dbg_req_nxt;
  logic        link_in_d_r;   // Previous link level
  logic        bus_req_r;
  logic        bus_we_r;
  logic [15:0] bus_addr_r;
  logic [7:0]  bus_wdata_r;

  // Core clock enable: oscillator divided by eight
  rsdc_clkdiv #(
    .DIV (`RSDC_CORE_DIV)
  ) u_div (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .sync_rst (rst_sync_r),
    .core_en  (core_en)
  ); // RQ15

  // Fetch sequencing
  rsdc_fetch u_fetch (
    .sys_clk      (sys_clk),
    .rst_b        (rst_b),
    .sync_rst     (rst_sync_r),
    .core_en      (core_en),
    .fetch_data   (fetch_data),
    .opcode_valid (opcode_valid),
    .pc           (pc),
    .in_unimpl    (in_unimpl),
    .opcode_bad   (opcode_bad)
  );

  // Supply monitor with rising and falling thresholds
  always_comb begin
    supply_ok_nxt = supply_ok_r;
    if (!supply_above_fall) supply_ok_nxt = 1'b0;      // RQ16
    else if (supply_above_rise) supply_ok_nxt = 1'b1;  // RQ2
  end

  // Gather every reset source; no pin input exists
  always_comb begin
    src_now = 6'h00;
    src_now[`RSDC_SRC_POR]     = !supply_ok_r;          // RQ1
    src_now[`RSDC_SRC_WDG_IND] = wdg_ind_event;         // RQ3
    src_now[`RSDC_SRC_WDG_WIN] = wdg_win_event;         // RQ3
    src_now[`RSDC_SRC_SOFT]    = soft_reset_req;        // RQ4
    src_now[`RSDC_SRC_DEBUG]   = dbg_req_r;             // RQ5
    src_now[`RSDC_SRC_OPCODE]  = opcode_bad;            // RQ6
  end

  // Combined reset: asserts two cycles after a source, releases on a core enable
  always_comb begin
    rst_hold_nxt = |src_now;                            // RQ17
    rst_sync_nxt = rst_sync_r;
    if (rst_hold_r) rst_sync_nxt = 1'b1;
    else if (core_en) rst_sync_nxt = 1'b0;
    cause_nxt = cause_r;
    if (|src_now) cause_nxt = src_now;
  end

  // Reset registers; power-up starts in reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_ok_r <= 1'b0;
      rst_hold_r  <= 1'b1;
      rst_sync_r  <= 1'b1;
      cause_r     <= `RSDC_CAUSE_RST;
    end else begin
      supply_ok_r <= supply_ok_nxt;
      rst_hold_r  <= rst_hold_nxt;
      rst_sync_r  <= rst_sync_nxt;
      cause_r     <= cause_nxt;
    end
  end

  // Debug link: long low pulse enters, then connected
  always_comb begin
    link_st_nxt = link_st_r;
    lcnt_nxt    = lcnt_r;
    dbg_req_nxt = 1'b0;
    if (rst_sync_r || pin_func == RSDC_PIN_GPIO) begin
      link_st_nxt = RSDC_LINK_IDLE;                     // RQ9 RQ11 RQ17
      lcnt_nxt    = 8'h00;
    end else begin
      unique case (link_st_r)
        RSDC_LINK_IDLE: begin
          // Host connects on the fly while code runs
          if (!link_in) lcnt_nxt = lcnt_r + 8'h01;      // RQ10
          else lcnt_nxt = 8'h00;
          if (!link_in && lcnt_r == `RSDC_LINK_ACTIVE_CY) begin
            link_st_nxt = RSDC_LINK_ENTRY;
            lcnt_nxt    = 8'h00;
          end
        end
        RSDC_LINK_ENTRY: begin
          // One acknowledge cycle, then wait for the line to return high;
          // a held acknowledge would keep the line low for ever
          lcnt_nxt = 8'h01;
          if (link_in) begin
            link_st_nxt = RSDC_LINK_CONNECTED;
            lcnt_nxt    = 8'h00;
          end
        end
        RSDC_LINK_CONNECTED: begin
          // Host reset request, held line low long
          if (!link_in) lcnt_nxt = lcnt_r + 8'h01;
          else lcnt_nxt = 8'h00;
          if (link_host_reset || (!link_in && lcnt_r == `RSDC_LINK_IDLE_CY)) begin
            dbg_req_nxt = 1'b1;                         // RQ5
            lcnt_nxt    = 8'h00;
          end
        end
      endcase
    end
  end

  // Link state registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      link_st_r   <= RSDC_LINK_IDLE;
      lcnt_r      <= 8'h00;
      dbg_req_r   <= 1'b0;
      link_in_d_r <= 1'b1;
    end else begin
      link_st_r   <= link_st_nxt;
      lcnt_r      <= lcnt_nxt;
      dbg_req_r   <= dbg_req_nxt;
      link_in_d_r <= link_in;
    end
  end

  // Non-halting memory access, relayed while connected
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_req_r   <= 1'b0;
      bus_we_r    <= 1'b0;
      bus_addr_r  <= 16'h0000;
      bus_wdata_r <= 8'h00;
    end else begin
      bus_req_r <= mem_req && (link_st_r == RSDC_LINK_CONNECTED); // RQ13
      if (mem_req) begin
        bus_we_r    <= mem_we;
        bus_addr_r  <= mem_addr;
        bus_wdata_r <= mem_wdata;
      end
    end
  end

  // Open-drain line: only ever pulls low, acknowledging entry
  assign link_out = 1'b0;                                           // RQ12
  // Acknowledge pulls low only in the first entry cycle
  assign link_oe  = (link_st_r == RSDC_LINK_ENTRY) && (lcnt_r == 8'h00) && !link_in_d_r; // RQ12
  assign link_connected   = (link_st_r == RSDC_LINK_CONNECTED);
  assign bus_req          = bus_req_r;
  assign bus_we           = bus_we_r;
  assign bus_addr         = bus_addr_r;
  assign bus_wdata        = bus_wdata_r;
  assign cpu_halt         = 1'b0;                                   // RQ13
  assign int_reset        = rst_sync_r;
  assign reset_cause      = cause_r;
  // Unbonded pins float as inputs during reset
  assign gpio_force_float = rst_sync_r ? gpio_unbonded : '0;        // RQ14

  // Assertions
  AST_WDG_RESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wdg_ind_event || wdg_win_event) |-> ##2 int_reset)
    else $error("watchdog did not reset"); // RQ3
  AST_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    soft_reset_req |-> ##2 int_reset)
    else $error("soft reset lost"); // RQ4
  AST_DBG_RESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    dbg_req_r |-> ##2 int_reset)
    else $error("debug reset lost"); // RQ5
  AST_OPC_RESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    opcode_bad |-> ##2 int_reset)
    else $error("illegal opcode reset lost"); // RQ6
  AST_SUPPLY_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !supply_ok_r |-> ##2 int_reset)
    else $error("reset released under low supply"); // RQ2
  AST_ABORT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    int_reset |=> !link_connected)
    else $error("link survived reset"); // RQ9
  AST_GPIO_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (pin_func == RSDC_PIN_GPIO) |=> (link_st_r == RSDC_LINK_IDLE))
    else $error("link active in gpio mode"); // RQ11
  AST_DIV8: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(core_en) && !int_reset |-> ##8 (core_en || int_reset))
    else $error("core enable not every eight"); // RQ15
  AST_FLOAT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    int_reset |-> gpio_force_float == gpio_unbonded)
    else $error("unbonded gpio not floated"); // RQ14
  AST_NO_HALT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    bus_req |-> !cpu_halt && $past(link_connected))
    else $error("access halted or not connected"); // RQ13
  AST_BUS_REFUSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mem_req && !link_connected |=> !bus_req)
    else $error("access relayed while not connected"); // RQ13
  AST_LINK_ACK: assert property (@(posedge sys_clk) disable iff (!rst_b)
    link_oe |=> !link_oe)
    else $error("acknowledge held too long"); // RQ12
  AST_PC_ADVANCE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    core_en && !int_reset |=> pc == $past(pc) + 16'h0001)
    else $error("pc did not advance"); // RQ7
  AST_PC_RESET: assert property (@(posedge sys_clk) disable iff (!rst_b)
    int_reset |=> pc == `RSDC_PC_RST)
    else $error("pc not returned to start"); // RQ17
  AST_RELEASE_SYNC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(int_reset) |-> $past(core_en))
    else $error("reset released off a core enable"); // RQ17
  AST_FLOAT_OFF: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !int_reset |-> gpio_force_float == '0)
    else $error("gpio forced outside reset"); // RQ14
  // Cover the main scenarios
  COV_CONNECT: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(link_connected));
  COV_ABORT: cover property (@(posedge sys_clk) disable iff (!rst_b)
    link_connected ##1 int_reset);
  COV_UNIMPL: cover property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(in_unimpl));
  COV_DBG_RESET: cover property (@(posedge sys_clk) disable iff (!rst_b)
    dbg_req_r ##2 int_reset);
  COV_OPC_RESET: cover property (@(posedge sys_clk) disable iff (!rst_b)
    opcode_bad ##2 int_reset);
endmodule
`default_nettype wire

// ==== rsdc_host_model.sv ====
// Debug host model on the open-drain single-wire debug link.
// Assumes the bench resolves the wire with a pull-up and feeds link_line back.
`timescale 1ns/1ps
`default_nettype none
module rsdc_host_model (
  input  wire logic        sys_clk,
  input  wire logic        link_line,
  output logic             host_oe,
  output logic             link_host_reset,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata
);
  // Idle: line released, no request
  initial begin
    host_oe         = 1'b0;
    link_host_reset = 1'b0;
    mem_req         = 1'b0;
    mem_we          = 1'b0;
    mem_addr        = 16'h0000;
    mem_wdata       = 8'h00;
  end
  // Released address and data churn so a stale value never looks valid
  always @(posedge sys_clk) begin
    if (!mem_req) begin
      mem_addr  <= ~mem_addr;
      mem_wdata <= ~mem_wdata;
    end
  end
  // Entry: pull the line low, then release it; only pulls, never drives high
  task automatic connect(input int low_cy);
    @(posedge sys_clk);
    #1 host_oe = 1'b1;
    repeat (low_cy) @(posedge sys_clk);
    #1 host_oe = 1'b0;
    // Return once the line reads high again, or after at most four cycles
    for (int i = 0; i < 4 && !link_line; i++) @(posedge sys_clk);
  endtask
  // Reset command pulse while connected
  task automatic send_reset();
    @(posedge sys_clk);
    #1 link_host_reset = 1'b1;
    @(posedge sys_clk);
    #1 link_host_reset = 1'b0;
  endtask
  // Memory access held for three edges while the program keeps running
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 mem_req = 1'b1;
    mem_we    = we;
    mem_addr  = a;
    mem_wdata = d;
    repeat (3) @(posedge sys_clk);
    #1 mem_req = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the reset source and debug connect block.
// Assumes the design, its header and the host model are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "rsdc_regs.svh"
module tb;
  import rsdc_pkg::*;
  localparam int NGPIO = 16;
  logic              sys_clk, rst_b, supply_above_rise, supply_above_fall;
  logic              wdg_ind_event, wdg_win_event, soft_reset_req, opcode_valid;
  logic [7:0]        fetch_data;
  rsdc_pin_t         pin_func;
  logic [NGPIO-1:0]  gpio_unbonded, gpio_force_float;
  logic              link_host_reset, mem_req, mem_we, host_oe;
  logic [15:0]       mem_addr, pc, bus_addr, p0;
  logic [7:0]        mem_wdata, bus_wdata;
  logic              int_reset, core_en, in_unimpl, link_out, link_oe;
  logic              link_connected, bus_req, bus_we, cpu_halt, link_in;
  logic [5:0]        reset_cause;
  logic [31:0]       seed = 32'h505e_5364;
  int                error_cnt = 0, total_checks = 0, t1, t2;
  // Open-drain wire with pull-up: low while either side pulls
  assign link_in = !(host_oe || (link_oe && !link_out));
  rsdc_top #(.NGPIO(NGPIO)) i_rsdc_top (.sys_clk, .rst_b, .supply_above_rise,
    .supply_above_fall, .wdg_ind_event, .wdg_win_event, .soft_reset_req, .fetch_data,
    .opcode_valid, .pin_func, .link_in, .link_host_reset, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .gpio_unbonded, .int_reset, .reset_cause, .core_en, .pc, .in_unimpl,
    .link_out, .link_oe, .link_connected, .bus_req, .bus_we, .bus_addr, .bus_wdata,
    .cpu_halt, .gpio_force_float);
  rsdc_host_model u_host (.sys_clk, .link_line(link_in), .host_oe, .link_host_reset,
    .mem_req, .mem_we, .mem_addr, .mem_wdata);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected cause vector bit for one source
  function automatic logic [5:0] cause_bit(input int src);
    return 6'h01 << src;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait on the internal reset level
  task automatic wait_rst(input logic lvl, input int maxc);
    for (int i = 0; i < maxc && int_reset !== lvl; i++) cyc(1);
  endtask
  // Hold one reset cause for a full core period, then clear all
  task automatic fire(input int src);
    @(posedge sys_clk);
    case (src)
      `RSDC_SRC_POR:     {supply_above_rise, supply_above_fall} <= 2'b00;
      `RSDC_SRC_WDG_IND: wdg_ind_event <= 1'b1;
      `RSDC_SRC_WDG_WIN: wdg_win_event <= 1'b1;
      `RSDC_SRC_SOFT:    soft_reset_req <= 1'b1;
      default: begin
        opcode_valid <= 1'b0;
        fetch_data   <= 8'(rnd()) | 8'h01;
      end
    endcase
    repeat (`RSDC_CORE_DIV) @(posedge sys_clk);
    {wdg_ind_event, wdg_win_event, soft_reset_req} <= 3'b000;
    {supply_above_rise, supply_above_fall, opcode_valid} <= 3'b111;
    fetch_data <= `RSDC_NEG_OPCODE;
    #1;
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog against hangs
  initial begin
    #(90_000 * 10);
    error_cnt++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {rst_b, supply_above_rise, wdg_ind_event, wdg_win_event, soft_reset_req} = 5'b0;
    {supply_above_fall, opcode_valid} = 2'b11;
    fetch_data    = `RSDC_NEG_OPCODE;
    pin_func      = RSDC_PIN_DEBUG;
    gpio_unbonded = NGPIO'(rnd());
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    u_host.connect(70);
    cyc(4);
    chk(link_connected, 0, "connect while held in reset");
    chk(int_reset, 1, "reset held below rising level");
    chk(reset_cause, `RSDC_CAUSE_RST, "power-on cause");
    chk(pc, `RSDC_PC_RST, "pc reset");
    chk(gpio_force_float, gpio_unbonded, "unbonded float in reset");
    @(posedge sys_clk);
    supply_above_rise <= 1'b1;
    wait_rst(0, 20);
    chk(int_reset, 0, "reset release");
    chk(gpio_force_float, 0, "float mask after reset");
    // Core enable spacing
    for (t1 = 0; t1 < 20 && core_en !== 1'b1; t1++) cyc(1);
    for (t2 = 1; t2 < 20; t2++) begin
      cyc(1);
      if (core_en === 1'b1) break;
    end
    chk(t2, `RSDC_CORE_DIV, "core enable period");
    // Zero bytes must be legal without help from the decoder
    @(posedge sys_clk);
    opcode_valid <= 1'b0;
    p0 = pc;
    cyc(64);
    chk(pc > p0, 1, "zero bytes advance pc");
    chk(int_reset, 0, "zero bytes legal");
    @(posedge sys_clk);
    supply_above_rise <= 1'b0;
    cyc(16);
    chk(int_reset, 0, "no reset between thresholds");
    // Each reset source except debug in turn
    for (int k = 0; k < 5; k++) begin
      t1 = (k == 4) ? `RSDC_SRC_OPCODE : k;
      fire(t1);
      wait_rst(1, 12);
      chk(int_reset, 1, "cause raises reset");
      chk(reset_cause & cause_bit(t1), cause_bit(t1), "cause bit");
      wait_rst(0, 30);
      chk(int_reset, 0, "release after cause");
    end
    // Connect, access memory, then host reset
    u_host.connect(70);
    for (t1 = 0; t1 < 10 && link_connected !== 1'b1; t1++) cyc(1);
    chk(link_connected, 1, "connect while running");
    for (int k = 0; k < 2; k++) begin
      p0 = rnd();
      t2 = rnd();
      fork
        u_host.access(k[0], p0, t2[7:0]);
        begin
          cyc(3);
          chk({bus_req, bus_we, bus_addr, bus_wdata}, {1'b1, k[0], p0, t2[7:0]}, "bus");
          chk(cpu_halt, 0, "no halt");
        end
      join
    end
    u_host.send_reset();
    wait_rst(1, 12);
    chk(reset_cause & cause_bit(`RSDC_SRC_DEBUG), cause_bit(`RSDC_SRC_DEBUG), "debug");
    cyc(1);
    chk(link_connected, 0, "reset aborts link");
    wait_rst(0, 30);
    // Watchdog aborts a live connection
    u_host.connect(70);
    cyc(8);
    fire(`RSDC_SRC_WDG_WIN);
    chk(link_connected, 0, "watchdog aborts link");
    wait_rst(0, 30);
    // Pin given to GPIO refuses connects
    @(posedge sys_clk);
    pin_func <= RSDC_PIN_GPIO;
    u_host.connect(70);
    cyc(10);
    chk(link_connected, 0, "gpio pin refuses link");
    chk(link_out, 0, "link never drives high");
    // Run off the end of program memory
    for (t1 = 0; t1 < 80_000 && in_unimpl !== 1'b1; t1++) cyc(1);
    chk(in_unimpl, 1, "past end of memory");
    chk(pc > `RSDC_PROG_END, 1, "pc beyond end");
    p0 = pc;
    cyc(32);
    chk(pc > p0, 1, "fetch continues");
    end_of_test();
  end
endmodule
`default_nettype wire
